/* verification/larmo_core_bench.sv */
// Self-checking bench for the move core: directed corners, then random moves.
// Assumes one word per four-clock cycle, the first Q1 right after reset release.
module larmo_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import larmo_pkg::*;

    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 1'b0;
    logic [7:0] file_rdata_i = 8'h00;
    logic instr_taken_o, file_re_o, file_we_o, unknown_op_o;
    logic [ADDR_W-1:0] file_addr_o;
    logic [7:0] file_wdata_o, w_o, bank_select_register_o;
    larmo_phase_e phase_o;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [7:0] ew = W_RESET;
    logic [7:0] eb = BANK_SELECT_RESET;
    logic [15:0] corner[] = '{16'h0e5a, 16'h6e00, 16'h6e7f, 16'h6e80, 16'h0eff, 16'h6eff,
        16'h01f3, 16'h6f10, 16'h6e90, 16'h0100, 16'h6fff};

    larmo_core larmo_core_i (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_taken_o(instr_taken_o),
        .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .file_re_o(file_re_o),
        .file_we_o(file_we_o), .file_rdata_i(file_rdata_i), .phase_o(phase_o), .w_o(w_o),
        .bank_select_register_o(bank_select_register_o), .unknown_op_o(unknown_op_o));

    // Free-running clock of 40 ns.
    initial forever #20 clk_i = ~clk_i;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Access bank split at 0x80 unless the word asks for the selected bank.
    function automatic logic [11:0] f_addr(input logic [15:0] wd, input logic [7:0] b);
        if (wd[8]) return {b[3:0], wd[7:0]};
        return {(wd[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK), wd[7:0]};
    endfunction : f_addr

    // One instruction cycle; state left by the previous word is checked in this Q2.
    task automatic exec(input logic [15:0] wd);
        logic st;
        logic uk;
        st = (wd[15:9] == OPC_STORE_W);
        uk = !(st || wd[15:8] == OPC_LOAD_W || wd[15:8] == OPC_LOAD_BANK);
        instr_i <= wd;
        instr_valid_i <= 1'b1;
        file_rdata_i <= 8'($urandom);
        @(posedge clk_i);
        check(12'(phase_o), 12'(PH_Q1), "phase");
        // Junk with valid outside Q1 must be ignored, so it is driven on purpose.
        instr_valid_i <= 1'($urandom);
        instr_i <= 16'($urandom);
        @(posedge clk_i);
        check(12'(instr_taken_o), 12'h001, "taken");
        check(12'(unknown_op_o), 12'(uk), "unknown");
        check(12'(file_re_o), 12'(st), "read");
        check(12'(w_o), 12'(ew), "w");
        check(12'(bank_select_register_o), 12'(eb), "bank select");
        if (st) check(file_addr_o, f_addr(wd, eb), "address");
        repeat (2) @(posedge clk_i);
        check(12'(file_we_o), 12'(st), "write");
        if (st) check(12'(file_wdata_o), 12'(ew), "write data");
        if (wd[15:8] == OPC_LOAD_W) ew = wd[7:0];
        if (wd[15:8] == OPC_LOAD_BANK) eb = wd[7:0];
    endtask : exec

    // Two-word copy: the source byte is read in Q2 of the first cycle and written in
    // Q4 of the second; the read data stays on the bus until the next transfer.
    task automatic copy_move(input logic [11:0] src, input logic [11:0] dst);
        logic [7:0] data;
        data = 8'($urandom);
        instr_i <= {OPC_COPY_SRC, src};
        instr_valid_i <= 1'b1;
        file_rdata_i <= data;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(posedge clk_i);
        check(12'(file_re_o), 12'h001, "copy read");
        check(file_addr_o, src, "copy source");
        check(12'(unknown_op_o), 12'h000, "copy unknown");
        repeat (2) @(posedge clk_i);
        instr_i <= {OPC_COPY_DST, dst};
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(posedge clk_i);
        check(12'(file_re_o), 12'h000, "copy second read");
        repeat (2) @(posedge clk_i);
        check(12'(file_we_o), 12'h001, "copy write");
        check(file_addr_o, dst, "copy destination");
        check(12'(file_wdata_o), 12'(data), "copy data");
    endtask : copy_move

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // Sequence and watchdog
    // ----------------------------------------------------------------
    // Corners first, then random moves; a lone copy-destination word flushes the checks
    // and, having no source word before it, is expected to raise the unknown flag.
    initial begin
        void'($urandom(56));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (corner[i]) exec(corner[i]);
        copy_move(12'h000, 12'hfff);
        copy_move(12'hf80, 12'h17f);
        exec(16'h01a5);
        // Mid-run reset: W and the bank select register must fall back at once.
        rst_i <= 1'b1;
        instr_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(12'(w_o), 12'(W_RESET), "w after reset");
        check(12'(bank_select_register_o), 12'(BANK_SELECT_RESET), "bank after reset");
        check(12'(phase_o), 12'(PH_Q1), "phase after reset");
        rst_i <= 1'b0;
        ew = W_RESET;
        eb = BANK_SELECT_RESET;
        repeat (200) begin
            case ($urandom % 4)
                0: exec({OPC_LOAD_W, 8'($urandom)});
                1: exec({OPC_LOAD_BANK, 8'($urandom)});
                2: exec({OPC_STORE_W, 9'($urandom)});
                default: copy_move(12'($urandom), 12'($urandom));
            endcase
        end
        exec(16'hf000);
        wrap_up();
    end

    // Roughly twice the planned run, so a stall cannot hang the simulator.
    initial begin
        #(CLK_PERIOD_NS * 4 * 600);
        error_cnt++;
        wrap_up();
    end
endmodule : larmo_core_bench

/* verification/larmo_core_properties.sv */
// Concurrent checks of the move core, written against its ports only.
// Assumes one clock and a synchronous active-high reset; bound after the module.
module larmo_core_properties
    import larmo_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction fetch
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic instr_taken_o,
    // Data memory
    input wire logic [larmo_pkg::ADDR_W-1:0] file_addr_o,
    input wire logic [7:0] file_wdata_o,
    input wire logic file_re_o,
    input wire logic file_we_o,
    input wire logic [7:0] file_rdata_i,
    // Core state
    input wire larmo_pkg::larmo_phase_e phase_o,
    input wire logic [7:0] w_o,
    input wire logic [7:0] bank_select_register_o,
    input wire logic unknown_op_o
);
    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // A word is taken only at the edge that ends Q1.
    sequence take_s;
        phase_o == PH_Q1 && instr_valid_i;
    endsequence
    sequence store_s;
        take_s ##0 instr_i[15:9] == OPC_STORE_W;
    endsequence
    sequence copy_src_s;
        take_s ##0 instr_i[15:12] == OPC_COPY_SRC;
    endsequence
    sequence copy_dst_s;
        take_s ##0 instr_i[15:12] == OPC_COPY_DST;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    phase_ring_a: assert property (phase_o == PH_Q1 |=> phase_o == PH_Q2 ##1 phase_o == PH_Q3
        ##1 phase_o == PH_Q4 ##1 phase_o == PH_Q1) else $error("phase order broken");
    taken_pulse_a: assert property (take_s |=> instr_taken_o ##1 !instr_taken_o)
        else $error("taken pulse wrong");
    load_working_a: assert property (take_s ##0 instr_i[15:8] == OPC_LOAD_W |-> ##4
        w_o == $past(instr_i[7:0], 4) && bank_select_register_o == $past(bank_select_register_o, 4))
        else $error("literal load to W wrong");
    load_bank_a: assert property (take_s ##0 instr_i[15:8] == OPC_LOAD_BANK |-> ##4
        bank_select_register_o == $past(instr_i[7:0], 4) && w_o == $past(w_o, 4))
        else $error("bank select load wrong");
    store_write_a: assert property (store_s |-> ##1 file_re_o ##2
        file_we_o && file_wdata_o == w_o) else $error("store write wrong");
    store_banked_a: assert property (store_s ##0 instr_i[8] |=>
        file_addr_o == {bank_select_register_o[3:0], $past(instr_i[7:0])})
        else $error("banked store address wrong");
    store_access_a: assert property (store_s ##0 !instr_i[8] |=> file_addr_o ==
        {($past(instr_i[7]) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK), $past(instr_i[7:0])})
        else $error("access bank address wrong");
    store_offset_a: assert property (store_s |-> ##3
        file_addr_o[7:0] == $past(instr_i[7:0], 3)) else $error("store offset wrong");
    // A pair only forms when the source word was taken without the unknown flag.
    copy_write_a: assert property (copy_src_s ##1 !unknown_op_o ##3 copy_dst_s |-> ##3
        file_we_o && file_addr_o == $past(instr_i[11:0], 3)
        && file_wdata_o == $past(file_rdata_i, 6)) else $error("file copy write wrong");
endmodule : larmo_core_properties

bind larmo_core larmo_core_properties larmo_core_properties_i (.clk_i(clk_i), .rst_i(rst_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .instr_taken_o(instr_taken_o),
    .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .file_re_o(file_re_o),
    .file_we_o(file_we_o), .file_rdata_i(file_rdata_i), .phase_o(phase_o), .w_o(w_o),
    .bank_select_register_o(bank_select_register_o), .unknown_op_o(unknown_op_o));

/* verilog/larmo_core.sv */
// Execution of the data-move instructions of an 8-bit core: bank-select literal load,
// working literal load, store of the working register to a file register, and the
// quadrature-phase activity of the two-word file-to-file copy.
// Assumes the fetch side holds instr_i steady through Q1 and that file_rdata_i answers
// a read within the Q2 phase in which file_re_o is high.
//
// Summary of operation
// - Bank-select literal load writes the literal into the bank select register only.
// - Opcode 0110 111a stores the working register into the addressed file register.
// - With the access bit set, the 8-bit file offset reaches every location of a 256-byte bank.
// - Access bit one takes the bank from the bank select register.
module larmo_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction fetch
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    output logic instr_taken_o,
    // Data memory
    output logic [larmo_pkg::ADDR_W-1:0] file_addr_o,
    output logic [7:0] file_wdata_o,
    output logic file_re_o,
    output logic file_we_o,
    input wire logic [7:0] file_rdata_i,
    // Core state
    output larmo_pkg::larmo_phase_e phase_o,
    output logic [7:0] w_o,
    output logic [7:0] bank_select_register_o,
    output logic unknown_op_o
);
    import larmo_pkg::*;

    larmo_op_e op;
    logic copy_pending;
    logic [7:0] literal;
    logic [ADDR_W-1:0] copy_dst;
    logic [7:0] copy_hold;
    logic take;

    // ----------------------------------------------------------------
    // Phase generator
    // ----------------------------------------------------------------
    larmo_qphase u_qphase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phase_o(phase_o)
    );

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Opcode classification of a single word that does not follow a copy source word.
    function automatic larmo_op_e decode_word(input logic [15:0] word);
        larmo_op_e res;
        res = OP_NONE;
        if (word[15:8] == OPC_LOAD_BANK) begin
            res = OP_LOAD_BANK;
        end else if (word[15:8] == OPC_LOAD_W) begin
            res = OP_LOAD_W;
        end else if (word[15:9] == OPC_STORE_W) begin
            res = OP_STORE_W;
        end else if (word[15:12] == OPC_COPY_SRC) begin
            res = OP_COPY_SRC;
        end
        return res;
    endfunction : decode_word

    // Forms a 12-bit data address from an 8-bit offset and the access bit.
    function automatic logic [ADDR_W-1:0] form_address(input logic [7:0] offset,
                                                       input logic use_bank,
                                                       input logic [7:0] bank);
        logic [3:0] sel;
        sel = ACCESS_LOW_BANK;
        if (use_bank) begin
            sel = bank[3:0];
        end else if (offset >= ACCESS_SPLIT) begin
            sel = ACCESS_HIGH_BANK;
        end
        return {sel, offset};
    endfunction : form_address

    // A word is taken at the end of Q1; a lone second copy word decodes as no operation.
    assign take = (phase_o == PH_Q1) && instr_valid_i;

    // ----------------------------------------------------------------
    // Instruction sequencing
    // ----------------------------------------------------------------
    // The operation stays latched from the end of Q1 and is retired at the end of Q4.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op <= OP_NONE;
            copy_pending <= 1'b0;
            literal <= 8'h00;
            copy_dst <= '0;
        end else begin
            case (phase_o)
                PH_Q1: begin
                    if (take) begin
                        literal <= instr_i[7:0];
                        if (copy_pending) begin
                            copy_pending <= 1'b0;
                            copy_dst <= instr_i[11:0];
                            op <= (instr_i[15:12] == OPC_COPY_DST) ? OP_COPY_DST : OP_NONE;
                        end else begin
                            op <= decode_word(instr_i);
                        end
                    end
                end
                PH_Q4: begin
                    // The second word must arrive in the very next cycle to pair.
                    copy_pending <= (op == OP_COPY_SRC);
                    op <= OP_NONE;
                end
                default: begin
                    op <= op;
                end
            endcase
        end
    end

    // Flags a fetched word that no decoder here recognises; one-cycle pulse in Q2.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unknown_op_o <= 1'b0;
            instr_taken_o <= 1'b0;
        end else begin
            instr_taken_o <= take;
            if (take) begin
                if (copy_pending) begin
                    unknown_op_o <= (instr_i[15:12] != OPC_COPY_DST);
                end else begin
                    unknown_op_o <= (decode_word(instr_i) == OP_NONE);
                end
            end else begin
                unknown_op_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Data memory strobes
    // ----------------------------------------------------------------
    // Read in Q2 and write in Q4, so a store never overlaps the read of the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            file_addr_o <= '0;
            file_wdata_o <= 8'h00;
            file_re_o <= 1'b0;
            file_we_o <= 1'b0;
        end else begin
            file_re_o <= 1'b0;
            file_we_o <= 1'b0;
            case (phase_o)
                PH_Q1: begin
                    if (take && !copy_pending) begin
                        if (decode_word(instr_i) == OP_STORE_W) begin
                            file_re_o <= 1'b1;
                            file_addr_o <= form_address(instr_i[7:0], instr_i[ACCESS_BIT],
                                                        bank_select_register_o);
                        end else if (decode_word(instr_i) == OP_COPY_SRC) begin
                            file_re_o <= 1'b1;
                            file_addr_o <= instr_i[11:0];
                        end
                    end
                end
                PH_Q3: begin
                    if (op == OP_STORE_W) begin
                        file_we_o <= 1'b1;
                        file_wdata_o <= w_o;
                    end else if (op == OP_COPY_DST) begin
                        file_we_o <= 1'b1;
                        file_addr_o <= copy_dst;
                        file_wdata_o <= copy_hold;
                    end
                end
                default: begin
                    file_addr_o <= file_addr_o;
                end
            endcase
        end
    end

    // Source byte of a copy, caught as the Q2 read completes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            copy_hold <= 8'h00;
        end else if (phase_o == PH_Q2 && op == OP_COPY_SRC) begin
            copy_hold <= file_rdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Core registers
    // ----------------------------------------------------------------
    // W changes at the end of Q4, so a store in the same cycle still sees the old value.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_o <= W_RESET;
        end else if (phase_o == PH_Q4 && op == OP_LOAD_W) begin
            w_o <= literal;
        end
    end

    // The whole literal is kept; only the low nibble takes part in addressing.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_select_register_o <= BANK_SELECT_RESET;
        end else if (phase_o == PH_Q4 && op == OP_LOAD_BANK) begin
            bank_select_register_o <= literal;
        end
    end

endmodule : larmo_core

/* verilog/larmo_pkg.sv */
// Constants, opcode fields and state encodings for the literal and register move core.
// Assumes one clock at 25 MHz, one machine phase per clock, four phases per cycle.
package larmo_pkg;

    // ----------------------------------------------------------------
    // Clock and instruction cycle
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int PHASES_PER_CYCLE = 4;

    // ----------------------------------------------------------------
    // Opcode fields
    // ----------------------------------------------------------------
    localparam logic [7:0] OPC_LOAD_BANK = 8'h01;  // Upper byte of the bank-select literal load.
    localparam logic [7:0] OPC_LOAD_W = 8'h0e;     // Upper byte of the working literal load.
    localparam logic [6:0] OPC_STORE_W = 7'h37;    // Bits 15:9 of the store to file.
    localparam logic [3:0] OPC_COPY_SRC = 4'hc;    // First word of the file-to-file copy.
    localparam logic [3:0] OPC_COPY_DST = 4'hf;    // Second word of the file-to-file copy.
    localparam int ACCESS_BIT = 8;                 // Position of the bank-access bit.

    // ----------------------------------------------------------------
    // Data memory layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;   // Offsets below this map to the low bank.
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [7:0] BANK_SELECT_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } larmo_phase_e;

    typedef enum logic [5:0] {
        OP_NONE = 6'b000001,
        OP_LOAD_BANK = 6'b000010,
        OP_LOAD_W = 6'b000100,
        OP_STORE_W = 6'b001000,
        OP_COPY_SRC = 6'b010000,
        OP_COPY_DST = 6'b100000
    } larmo_op_e;

endpackage : larmo_pkg

/* verilog/larmo_qphase.sv */
// Four-phase instruction cycle generator: one phase per clock, Q1 through Q4.
// Assumes a synchronous active-high reset; the first phase after reset is Q1.
module larmo_qphase (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Phase
    output larmo_pkg::larmo_phase_e phase_o
);
    import larmo_pkg::*;

    // ----------------------------------------------------------------
    // Phase ring
    // ----------------------------------------------------------------
    // A one-hot ring keeps each phase decode to a single flop bit.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_o <= PH_Q1;
        end else begin
            case (phase_o)
                PH_Q1: phase_o <= PH_Q2;
                PH_Q2: phase_o <= PH_Q3;
                PH_Q3: phase_o <= PH_Q4;
                PH_Q4: phase_o <= PH_Q1;
                default: phase_o <= PH_Q1;
            endcase
        end
    end

endmodule : larmo_qphase
